// ### shared/cam_feat_pkg.sv
// shared offsets, field positions and resets of the camera feature registers
package cam_feat_pkg;
    // register offsets on the serial bus register space
    localparam logic [11:0] OFF_GAIN  = 12'h820;
    localparam logic [11:0] OFF_IRIS  = 12'h824;
    localparam logic [11:0] OFF_FOCUS = 12'h828;
    localparam logic [11:0] OFF_TEMP  = 12'h82C;
    // field positions; quadlet bit 0 is the msb, so bit n sits at 31-n
    localparam int BIT_PRES  = 31;
    localparam int BIT_ABS   = 30;
    localparam int BIT_PUSH  = 26;
    localparam int BIT_ON    = 25;
    localparam int BIT_AUTO  = 24;
    localparam int VAL_MSB   = 11;
    localparam int VAL_W     = 12;
    // quadlet bits 2-4 and 8-19 are reserved
    localparam logic [31:0] RSVD_MASK = 32'h38FF_F000;
    // reset values of the writable fields
    localparam logic [11:0] VAL_RST  = 12'h000;
    localparam logic        ABS_RST  = 1'b0;
    localparam logic        AUTO_RST = 1'b0;
    localparam logic        ON_RST   = 1'b1;
    // feature slots with a control value
    localparam int N_FEAT   = 3;
    localparam int IDX_GAIN = 0;
    // one-push sequencer states, gray along idle -> run -> idle
    typedef enum logic [1:0] {
        ADJ_IDLE = 2'b00,
        ADJ_RUN  = 2'b01
    } adj_state_t;
endpackage

// ### hdl/one_push_seq.sv
// one-push automatic adjustment sequencer for a single feature
`timescale 1ns/1ns
module one_push_seq
    import cam_feat_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic start,     // one-cycle request from a register write
    input  wire logic cancel,    // auto mode entered, drop the adjustment
    input  wire logic done,      // adjuster reports the pass finished
    output logic      busy       // reads back as the one-push bit
);
    adj_state_t state_r;         // sequencer state
    adj_state_t state_nxt;       // next state

    // next state; a start while running is simply absorbed
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ADJ_IDLE: begin
                if (start) begin
                    state_nxt = ADJ_RUN;
                end
            end
            ADJ_RUN: begin
                // self-clear when the pass ends or auto takes over
                if (done || cancel) begin
                    state_nxt = ADJ_IDLE;
                end
            end
            default: begin
                state_nxt = ADJ_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= ADJ_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign busy = (state_r == ADJ_RUN);

    a_push_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        busy && done |=> !busy) // see RL7
        else $error("one-push bit did not self-clear after done");
endmodule

// ### hdl/feature_regs.sv
// camera feature control registers: gain, iris, focus and temperature
// Function
// RL1: gain control register at offset 820h
// RL2: manual-abs: value field read-only, shows converted gain
// RL3: manual: value field drives gain, abs reads current
// RL4: auto: exposure controller drives gain, both read-only
// RL5: bit 0 reads one when feature present
// RL6: bit 1 picks value field or absolute register
// RL7: bit 5 write one starts adjustment, self-clears
// RL8: on/off bit zero makes other fields read-only
// RL9: gain and temperature on/off fixed at one
// RL10: gain bit 7 selects and reports manual/auto
// RL11: value in bits 20-31, auto-mode writes dropped
// RL12: temperature register at offset 82Ch reports board
// RL13: temperature value in tenths of a kelvin
// RL14: temperature abs bit makes value read-only
// RL15: temperature bit 7 is read-only mode report
// RL16: iris register at 824h, common layout
// RL17: focus register at 828h, common layout
// RL18: reserved bits read zero, writes ignored
// RL19: quadlet bit 0 is the word msb
// RL20: absent feature reads zero presence, ignores writes
`timescale 1ns/1ns
module feature_regs
    import cam_feat_pkg::*;
#(
    parameter logic [2:0] FEAT_PRESENT = 3'b001, // bit 0 gain, bit 1 iris, bit 2 focus; only gain by default
    parameter logic       TEMP_PRESENT = 1'b1
)(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        reg_wr,          // register write strobe
    input  wire logic        reg_rd,          // register read strobe
    input  wire logic [11:0] reg_addr,        // register offset
    input  wire logic [31:0] reg_wdata,       // write quadlet
    output logic      [31:0] reg_rdata,       // read quadlet
    output logic             reg_rvalid,      // read data valid pulse
    input  wire logic [11:0] abs_gain_conv,   // absolute gain, converted
    input  wire logic        ae_enable,       // exposure controller on
    input  wire logic [11:0] ae_gain,         // exposure controller gain
    input  wire logic [2:0]  adj_done,        // one-push pass finished
    input  wire logic [11:0] temp_tenth_k,    // board temp, 0.1 K units
    output logic      [11:0] gain_out,        // gain in effect
    output logic             gain_abs_mode,   // gain from absolute reg when not in auto
    output logic             gain_auto,       // gain in auto mode
    output logic             abs_gain_lock,   // absolute reg read-only
    output logic             temp_abs_mode,   // temp abs control bit
    output logic      [2:0]  adj_busy,        // one-push running
    output logic      [11:0] iris_value,      // aperture setting
    output logic      [11:0] focus_value,     // focus setting
    output logic      [1:0]  lens_on,         // iris, focus enabled
    output logic      [1:0]  lens_auto        // iris, focus auto mode
);
    logic [11:0] val_r  [N_FEAT];  // value fields
    logic        abs_r  [N_FEAT];  // absolute control bits
    logic        auto_r [N_FEAT];  // auto/manual bits
    logic        on_r   [N_FEAT];  // on/off bits
    logic        temp_abs_r;       // temperature absolute control
    logic [31:0] rdata_r;          // registered read data
    logic        rvalid_r;         // read answer pulse
    logic [11:0] gain_r;           // gain in effect
    logic [11:0] gain_nxt;         // next gain
    logic [2:0]  hit;              // write hits a present feature
    logic [2:0]  push_go;          // one-push start pulses
    logic        temp_hit;         // write hits temperature
    logic [2:0]  rd_sel_r;         // which register the last read hit

    // slot offsets in slot order
    function automatic logic [11:0] slot_off(input int i);
        unique case (i)
            0:       slot_off = OFF_GAIN;   // see RL1
            1:       slot_off = OFF_IRIS;   // see RL16
            default: slot_off = OFF_FOCUS;  // see RL17
        endcase
    endfunction

    // assemble a quadlet from fields; bit 0 is the msb
    function automatic logic [31:0] pack(input logic pres, input logic abs,
                                         input logic push, input logic on,
                                         input logic auto,
                                         input logic [11:0] val);
        logic [31:0] w;
        w = 32'h0000_0000;               // reserved bits stay zero, see RL18
        if (pres) begin
            w[BIT_PRES]      = 1'b1;     // see RL5
            w[BIT_ABS]       = abs;      // see RL19
            w[BIT_PUSH]      = push;
            w[BIT_ON]        = on;
            w[BIT_AUTO]      = auto;
            w[VAL_MSB:0]     = val;
        end
        pack = w;                        // absent reads all zero, see RL20
    endfunction

    // write decode; absent features take no writes
    always_comb begin
        for (int i = 0; i < N_FEAT; i++) begin
            hit[i] = reg_wr && (reg_addr == slot_off(i))
                     && FEAT_PRESENT[i];                   // see RL20
            // start only when on and manual, else ignored
            push_go[i] = hit[i] && reg_wdata[BIT_PUSH] && on_r[i]
                         && !auto_r[i];                    // see RL7
        end
        temp_hit = reg_wr && (reg_addr == OFF_TEMP) && TEMP_PRESENT;
    end

    // on/off bits; gain is wired on and ignores writes
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < N_FEAT; i++) begin
            if (!rst_n) begin
                on_r[i] <= ON_RST;
            end else if (hit[i] && i != IDX_GAIN) begin
                on_r[i] <= reg_wdata[BIT_ON];
            end else if (i == IDX_GAIN) begin
                on_r[i] <= 1'b1;                           // see RL9
            end
        end
    end

    // mode bits: frozen while the feature is off
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < N_FEAT; i++) begin
            if (!rst_n) begin
                abs_r[i]  <= ABS_RST;
                auto_r[i] <= AUTO_RST;
            end else if (hit[i] && on_r[i]) begin          // see RL8
                abs_r[i]  <= reg_wdata[BIT_ABS];           // see RL6
                auto_r[i] <= reg_wdata[BIT_AUTO];          // see RL10
            end
        end
    end

    // value fields: writable only when on and in plain manual mode;
    // a quadlet that itself selects auto or abs carries no value
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < N_FEAT; i++) begin
            if (!rst_n) begin
                val_r[i] <= VAL_RST;
            end else if (hit[i] && on_r[i] && !auto_r[i] && !abs_r[i]
                         && !reg_wdata[BIT_AUTO]            // see RL11
                         && !reg_wdata[BIT_ABS]) begin      // see RL6
                val_r[i] <= reg_wdata[VAL_MSB:0];
            end
        end
    end

    // temperature abs bit; on is fixed and the value is sensor-only
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            temp_abs_r <= ABS_RST;
        end else if (temp_hit) begin
            temp_abs_r <= reg_wdata[BIT_ABS];              // see RL14
        end
    end

    // one sequencer per feature; auto mode cancels a pending pass
    for (genvar g = 0; g < N_FEAT; g++) begin : g_push
        one_push_seq u_seq (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .start   (push_go[g]),
            .cancel  (auto_r[g]),
            .done    (adj_done[g]),
            .busy    (adj_busy[g])
        );
    end

    // gain source: auto w/ controller, absolute register, or value field
    always_comb begin
        if (auto_r[IDX_GAIN] && ae_enable) begin
            gain_nxt = ae_gain;                            // see RL4
        end else if (auto_r[IDX_GAIN]) begin
            gain_nxt = gain_r;    // controller off: hold last gain
        end else if (abs_r[IDX_GAIN]) begin
            gain_nxt = abs_gain_conv;                      // see RL2
        end else begin
            gain_nxt = val_r[IDX_GAIN];                    // see RL3
        end
    end

    // gain in effect, registered so the sensor sees clean steps
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gain_r <= VAL_RST;
        end else begin
            gain_r <= gain_nxt;
        end
    end

    // read path; the answer comes one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_r  <= 32'h0000_0000;
            rvalid_r <= 1'b0;
            rd_sel_r <= 3'h0;
        end else begin
            rvalid_r <= reg_rd;
            rd_sel_r <= 3'h0;
            if (reg_rd) begin
                unique case (reg_addr)
                    OFF_GAIN: begin
                        // gain value shows what is in effect
                        rdata_r  <= pack(FEAT_PRESENT[0], abs_r[0],
                                         adj_busy[0], on_r[0], auto_r[0],
                                         gain_r);          // see RL2
                        rd_sel_r <= 3'h1;
                    end
                    OFF_IRIS: begin
                        rdata_r  <= pack(FEAT_PRESENT[1], abs_r[1],
                                         adj_busy[1], on_r[1], auto_r[1],
                                         val_r[1]);
                        rd_sel_r <= 3'h2;
                    end
                    OFF_FOCUS: begin
                        rdata_r  <= pack(FEAT_PRESENT[2], abs_r[2],
                                         adj_busy[2], on_r[2], auto_r[2],
                                         val_r[2]);
                        rd_sel_r <= 3'h3;
                    end
                    OFF_TEMP: begin
                        // mode bit reports manual, never written
                        rdata_r  <= pack(TEMP_PRESENT, temp_abs_r, 1'b0,
                                         1'b1, 1'b0,       // see RL15
                                         temp_tenth_k);    // see RL13
                        rd_sel_r <= 3'h4;                  // see RL12
                    end
                    default: begin
                        rdata_r <= 32'h0000_0000;  // unmapped reads zero
                    end
                endcase
            end
        end
    end

    assign reg_rdata     = rdata_r;
    assign reg_rvalid    = rvalid_r;
    assign gain_out      = gain_r;
    assign gain_abs_mode = abs_r[IDX_GAIN];
    assign gain_auto     = auto_r[IDX_GAIN];
    // absolute gain writable only in manual-absolute state
    assign abs_gain_lock = auto_r[IDX_GAIN] || !abs_r[IDX_GAIN]; // see RL3
    assign temp_abs_mode = temp_abs_r;
    assign iris_value    = val_r[1];
    assign focus_value   = val_r[2];
    assign lens_on       = {on_r[2], on_r[1]};
    assign lens_auto     = {auto_r[2], auto_r[1]};

    a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RL18
        reg_rvalid |-> (reg_rdata & RSVD_MASK) == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    a_gain_on_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RL9
        reg_rvalid && rd_sel_r == 3'h1 && FEAT_PRESENT[0]
        |-> reg_rdata[BIT_ON])
        else $error("gain on/off bit read as off");

    a_auto_val_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RL11
        hit[0] && auto_r[0] |=> val_r[0] == $past(val_r[0]))
        else $error("gain value changed by a write in auto mode");

    a_abs_source: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RL6
        abs_r[0] && !auto_r[0] |=> gain_out == $past(abs_gain_conv))
        else $error("gain not taken from absolute register");

    a_manual_src: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RL3
        !abs_r[0] && !auto_r[0] ##1 !abs_r[0] && !auto_r[0]
        |-> gain_out == $past(val_r[0]) && abs_gain_lock)
        else $error("manual gain does not follow the value field");

    a_push_start: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RL7
        push_go[0] && !adj_done[0] |=> adj_busy[0])
        else $error("one-push write did not start an adjustment");

    a_push_in_auto: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RL7
        hit[0] && auto_r[0] && !adj_busy[0] |=> !adj_busy[0])
        else $error("one-push started while in auto mode");

    a_absent_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RL20
        reg_rvalid && ((rd_sel_r == 3'h2 && !FEAT_PRESENT[1])
                       || (rd_sel_r == 3'h3 && !FEAT_PRESENT[2]))
        |-> reg_rdata == 32'h0000_0000)
        else $error("absent lens register reads nonzero");

    a_temp_value: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RL13
        reg_rvalid && rd_sel_r == 3'h4 && TEMP_PRESENT
        |-> reg_rdata[VAL_MSB:0] == $past(temp_tenth_k)
            && !reg_rdata[BIT_AUTO])
        else $error("temperature read does not match the sensor");
endmodule

// ### test/feature_regs_tb.sv
// self-checking bench for the camera feature control registers
`timescale 1ns/1ns
module feature_regs_tb
    import cam_feat_pkg::*;
;
    logic        ref_clk = 1'b0;    // 50 MHz system clock
    logic        rst_n = 1'b0;      // synchronous reset, low active
    logic        reg_wr = 1'b0;     // write strobe
    logic        reg_rd = 1'b0;     // read strobe
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic        reg_rvalid;
    logic [11:0] abs_gain_conv = 12'h3A5; // converted absolute gain
    logic        ae_enable = 1'b0;
    logic [11:0] ae_gain = 12'h2B4;
    logic [2:0]  adj_done = 3'h0;
    logic [11:0] temp_tenth_k = 12'hBA7;  // 298.3 K
    logic [11:0] gain_out, iris_value, focus_value;
    logic        gain_abs_mode, gain_auto, abs_gain_lock, temp_abs_mode;
    logic [2:0]  adj_busy;
    logic [1:0]  lens_on, lens_auto;
    int          fail_count = 0;    // mismatches seen
    int          n_checks = 0;      // comparisons made
    int          cycles = 0;        // watchdog count

    // focus left absent so the absent-slot path is exercised
    feature_regs #(.FEAT_PRESENT(3'b011), .TEMP_PRESENT(1'b1)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .abs_gain_conv(abs_gain_conv),
        .ae_enable(ae_enable), .ae_gain(ae_gain), .adj_done(adj_done),
        .temp_tenth_k(temp_tenth_k), .gain_out(gain_out),
        .gain_abs_mode(gain_abs_mode), .gain_auto(gain_auto),
        .abs_gain_lock(abs_gain_lock), .temp_abs_mode(temp_abs_mode),
        .adj_busy(adj_busy), .iris_value(iris_value),
        .focus_value(focus_value), .lens_on(lens_on), .lens_auto(lens_auto));

    // free-running clock, 20 ns period
    always #10 ref_clk = ~ref_clk;

    // watchdog: the whole run needs well under 1000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    // single compare point, counts and reports
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    // one write quadlet; returns at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // one read; data checked under a mask while rvalid stands
    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                      input logic [31:0] m);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(32'(reg_rvalid), 32'h1, "rvalid");
        chk(reg_rdata & m, exp, "rdata");
    endtask

    // wait until registered outputs follow the last write
    task automatic settle();
        @(posedge ref_clk);
        #1;
    endtask

    // reset image of gain and temperature
    task automatic t_reset();
        rd(OFF_GAIN, 32'h8200_0000, 32'hFFFF_FFFF);
        rd(OFF_TEMP, 32'h8200_0BA7, 32'hFFFF_FFFF);
        $display("test reset done");
    endtask

    // manual gain with reserved bits set and an attempt to switch off
    task automatic t_manual();
        wr(OFF_GAIN, 32'h38FF_F123);
        settle();
        chk(32'(gain_out), 32'h123, "manual gain");
        chk(32'(abs_gain_lock), 32'h1, "abs lock");
        rd(OFF_GAIN, 32'h8200_0123, 32'hFFFF_FFFF);
        $display("test manual done");
    endtask

    // absolute control: value field ignored, shows converted gain
    task automatic t_abs();
        wr(OFF_GAIN, 32'h4000_0456);
        settle();
        chk(32'(gain_abs_mode), 32'h1, "abs mode");
        chk(32'(gain_out), 32'h3A5, "abs gain");
        chk(32'(abs_gain_lock), 32'h0, "abs lock");
        rd(OFF_GAIN, 32'hC200_03A5, 32'hFFFF_FFFF);
        $display("test abs done");
    endtask

    // one push starts in manual and clears on the done pulse
    task automatic t_push();
        wr(OFF_GAIN, 32'h0400_0123);
        #1;
        chk(32'(adj_busy), 32'h1, "push busy");
        rd(OFF_GAIN, 32'h8600_0123, 32'hFFFF_FFFF);
        @(posedge ref_clk);
        adj_done <= 3'h1;
        @(posedge ref_clk);
        adj_done <= 3'h0;
        #1;
        chk(32'(adj_busy[0]), 32'h0, "push cleared");
        $display("test push done");
    endtask

    // auto mode: controller drives gain, value writes and push dropped
    task automatic t_auto();
        @(posedge ref_clk);
        ae_enable <= 1'b1;
        wr(OFF_GAIN, 32'h0100_0777);
        settle();
        chk(32'(gain_out), 32'h2B4, "auto gain");
        chk(32'(gain_auto), 32'h1, "auto flag");
        chk(32'(abs_gain_lock), 32'h1, "auto lock");
        rd(OFF_GAIN, 32'h8300_02B4, 32'hFFFF_FFFF);
        wr(OFF_GAIN, 32'h0500_0111);
        #1;
        chk(32'(adj_busy), 32'h0, "push in auto");
        @(posedge ref_clk);
        ae_enable <= 1'b0;
        ae_gain <= 12'h0F0;
        settle();
        settle();
        chk(32'(gain_out), 32'h2B4, "auto hold");
        // leaving auto drops the value carried in the same quadlet
        wr(OFF_GAIN, 32'h0000_0050);
        settle();
        chk(32'(gain_out), 32'h123, "back to manual");
        wr(OFF_GAIN, 32'h0000_0050);
        settle();
        chk(32'(gain_out), 32'h050, "manual value");
        $display("test auto done");
    endtask

    // iris off freezes other fields; absent focus reads no presence
    task automatic t_lens();
        wr(OFF_IRIS, 32'h0000_00AB);
        settle();
        chk(32'(iris_value), 32'h0AB, "iris value");
        chk(32'(lens_on), 32'h2, "iris off");
        wr(OFF_IRIS, 32'h0100_00CD);
        settle();
        chk(32'(iris_value), 32'h0AB, "iris frozen");
        chk(32'(lens_auto[0]), 32'h0, "iris auto frozen");
        rd(OFF_IRIS, 32'h8000_00AB, 32'hFFFF_FFFF);
        wr(OFF_IRIS, 32'h0200_0000);
        settle();
        chk(32'(lens_on[0]), 32'h1, "iris on");
        wr(OFF_FOCUS, 32'h0200_0FFF);
        settle();
        chk(32'(focus_value), 32'h000, "focus absent");
        rd(OFF_FOCUS, 32'h0000_0000, 32'hFFFF_FFFF);
        $display("test lens done");
    endtask

    // temperature: only the abs bit takes a write
    task automatic t_temp();
        wr(OFF_TEMP, 32'h4500_0123);
        settle();
        chk(32'(temp_abs_mode), 32'h1, "temp abs");
        @(posedge ref_clk);
        temp_tenth_k <= 12'hC1C;
        rd(OFF_TEMP, 32'hC200_0C1C, 32'hFFFF_FFFF);
        wr(12'h830, 32'hFFFF_FFFF);
        rd(12'h830, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(OFF_GAIN, 32'h8200_0050, 32'hFFFF_FFFF);
        $display("test temp done");
    endtask

    // closing report, the only exit of the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_manual();
        t_abs();
        t_push();
        t_auto();
        t_lens();
        t_temp();
        give_verdict();
    end
endmodule
